// file: verilog/lftm_pkg.sv
// Purpose: Shared constants for the LED fault and thermal monitor.
// Assumes: Sensor words are codes from on-chip converters, scaled as noted below.
// Notes: Sink and supply voltages are 25 mV and 50 mV per code; temperature is 1/8 degC.
package lftm_pkg;
	// Register offsets (8-bit data, byte addresses)
	localparam logic [7:0] ADDR_FAULT = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h01;
	localparam logic [7:0] ADDR_CTRL = 8'h02;
	localparam logic [7:0] ADDR_TEMP_HI = 8'h03;
	localparam logic [7:0] ADDR_TEMP_LO = 8'h04;
	localparam logic [7:0] ADDR_STRINGS = 8'h05;
	localparam logic [7:0] ADDR_BOOST = 8'h06;
	// Fault register field positions
	localparam int FB_OPEN = 0;
	localparam int FB_SHORT = 1;
	localparam int FB_COUNT = 2;
	localparam int FB_SUPPLY = 5;
	localparam int FB_OVERCUR = 6;
	localparam int FB_THERMAL = 7;
	// Configuration register fields
	localparam int CB_HEADROOM = 0;
	localparam int CB_MARGIN = 3;
	localparam int CB_SUPPLY = 4;
	localparam int CB_DERATE = 6;
	// Values after reset, and the boost ceiling
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic CTRL_RST = 1'b0;
	localparam logic [7:0] BOOST_INIT = 8'ha0;
	localparam logic [7:0] BOOST_MAX = 8'hf0;
	// Adaptive step is 125 mV, which is five sink codes
	localparam logic [7:0] STEP_CODES = 8'h05;
	// Mismatch margins, 3.3 V and 5.3 V in sink codes
	localparam logic [8:0] MARGIN_LO = 9'h084;
	localparam logic [8:0] MARGIN_HI = 9'h0d4;
	// Supply thresholds 2.7 / 5.4 / 8.1 V and 200 mV hysteresis
	localparam logic [7:0] SUPPLY_THR1 = 8'h36;
	localparam logic [7:0] SUPPLY_THR2 = 8'h6c;
	localparam logic [7:0] SUPPLY_THR3 = 8'ha2;
	localparam logic [7:0] SUPPLY_HYST = 8'h04;
	// Thermal figures in whole degC; full duty in percent
	localparam logic [7:0] DERATE_T1 = 8'h6e;
	localparam logic [7:0] DERATE_T2 = 8'h78;
	localparam logic [7:0] DERATE_T3 = 8'h82;
	localparam logic [7:0] TSD_ON = 8'h96;
	localparam logic [7:0] TSD_OFF = 8'h82;
	localparam logic [6:0] DUTY_FULL = 7'h64;
	// Boost adjust interval
	localparam int STEP_PERIOD_US = 100;
	localparam int CLK_MHZ = 125;
	localparam int STEP_CYCLES_DEF = STEP_PERIOD_US * CLK_MHZ;
	// Bundled pin width passing the synchroniser
	localparam int SYNC_W = 58;
endpackage : lftm_pkg

// file: verilog/lftm_sync.sv
// Purpose: Two-stage synchroniser for pins and converter words.
// Assumes: Multi-bit words change slowly against mclk.
// Notes: The first stage feeds only the second stage.
module lftm_sync #(
	parameter int W = 1
) (
	// Clock
	input wire logic mclk,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// Two flops; a torn word lasts one cycle at most
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			meta_r <= '0;
			dout <= '0;
		end
		else
		begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : lftm_sync

// file: verilog/lftm_derate.sv
// Purpose: Brightness derating from die temperature.
// Assumes: Temperature in whole degC; selection field as in the package.
// Notes: Purely combinational; the caller registers the result.
module lftm_derate (
	// Inputs
	input wire logic [7:0] degC,
	input wire logic [1:0] derateThresholdSel,
	// Result in percent of full scale
	output logic [6:0] duty
);
	import lftm_pkg::*;
	logic [7:0] limit;
	logic [8:0] drop;

	// Two percent per degree above the limit, floored at zero
	always_comb
	begin
		case (derateThresholdSel)
			2'b01: limit = DERATE_T1;
			2'b10: limit = DERATE_T2;
			2'b11: limit = DERATE_T3;
			default: limit = 8'h00;
		endcase
		drop = {(degC - limit), 1'b0};
		if (limit == 8'h00 || degC < limit)
			duty = DUTY_FULL;
		else if (drop >= {2'b00, DUTY_FULL})
			duty = 7'h00;
		else
			duty = DUTY_FULL - drop[6:0];
	end
endmodule : lftm_derate

// file: verilog/lftm_monitor.sv
// Purpose: Fault supervision, adaptive boost tracking and thermal derating.
// Assumes: Sensor words arrive from other domains and are synchronised here.
// Notes: Enable pin low holds everything off and clears every fault.
module lftm_monitor #(
	parameter int unsigned STEP_CYCLES = lftm_pkg::STEP_CYCLES_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Chip pins
	input wire logic enPin,
	input wire logic autoDimMode,
	// Sensors
	input wire logic [3:0][7:0] sinkVolt,
	input wire logic [3:0] openCmp,
	input wire logic [7:0] supplyVolt,
	input wire logic overCurrent,
	input wire logic [10:0] tempCode,
	// Power stage
	output logic ledEnable,
	output logic boostEnable,
	output logic [7:0] boostSetpoint,
	output logic [6:0] dutyScale,
	// Fault pin, open drain
	output logic faultPinOut,
	output logic faultPinOe
);
	import lftm_pkg::*;

	// Headroom target in sink codes
	function automatic logic [7:0] headroomCode(input logic [2:0] sel);
		case (sel)
			3'd0: headroomCode = 8'h0c;
			3'd1: headroomCode = 8'h11;
			3'd2: headroomCode = 8'h16;
			3'd3: headroomCode = 8'h1b;
			3'd4: headroomCode = 8'h20;
			3'd5: headroomCode = 8'h25;
			3'd6: headroomCode = 8'h2a;
			default: headroomCode = 8'h30;
		endcase
	endfunction : headroomCode

	// Supply threshold; zero means detection off
	function automatic logic [7:0] supplyThr(input logic [1:0] sel);
		case (sel)
			2'b01: supplyThr = SUPPLY_THR1;
			2'b10: supplyThr = SUPPLY_THR2;
			2'b11: supplyThr = SUPPLY_THR3;
			default: supplyThr = 8'h00;
		endcase
	endfunction : supplyThr

	// Synchronised pins
	logic [SYNC_W-1:0] pinRaw;
	logic [SYNC_W-1:0] pinSync;
	logic enS;
	logic autoDimS;
	logic [3:0][7:0] sinkS;
	logic [3:0] openS;
	logic [7:0] supplyS;
	logic overCurS;
	logic [10:0] tempS;

	assign pinRaw = {enPin, autoDimMode, sinkVolt, openCmp, supplyVolt, overCurrent, tempCode};

	lftm_sync #(
		.W(SYNC_W)
	) u_sync (
		.mclk(mclk),
		.srst(srst),
		.din(pinRaw),
		.dout(pinSync)
	);

	assign {enS, autoDimS, sinkS, openS, supplyS, overCurS, tempS} = pinSync;

	// Software-visible state
	logic [7:0] cfg_r;
	logic faultInPwm_r;
	logic openFlag_r;
	logic shortFlag_r;
	logic supplyFlag_r;
	logic overCurFlag_r;
	logic thermalFlag_r;
	logic [3:0] stringBad_r;
	logic [2:0] tempLoHold_r;
	logic uvActive_r;
	logic tsdActive_r;
	logic [7:0] setpoint_r;
	logic [$clog2(STEP_CYCLES+1)-1:0] stepCnt_r;
	logic stepTick;

	// Decoded access and clear conditions
	logic faultRead;
	logic clrFaults;
	logic shutdown;
	logic checkStrings;
	logic [7:0] degC;
	logic [7:0] uvThr;
	logic [7:0] target;
	logic [8:0] margin;

	assign faultRead = regRd && regAddr == ADDR_FAULT;
	assign clrFaults = faultRead || !enS;
	assign degC = tempS[10:3];
	assign uvThr = supplyThr(cfg_r[CB_SUPPLY +: 2]);
	assign target = headroomCode(cfg_r[CB_HEADROOM +: 3]);
	assign margin = cfg_r[CB_MARGIN] ? MARGIN_HI : MARGIN_LO;
	assign shutdown = !enS || uvActive_r || tsdActive_r || overCurFlag_r;
	assign checkStrings = enS && !shutdown && (autoDimS || faultInPwm_r);

	// Configuration and control writes
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cfg_r <= CFG_RST;
			faultInPwm_r <= CTRL_RST;
		end
		else if (regWr)
		begin
			if (regAddr == ADDR_CFG)
				cfg_r <= regWdata;
			if (regAddr == ADDR_CTRL)
				faultInPwm_r <= regWdata[0];
		end
	end

	// Smallest headroom among strings still in the loop
	logic [7:0] minHead;
	logic anyIn;
	always_comb
	begin
		minHead = 8'hff;
		anyIn = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (!stringBad_r[i])
			begin
				anyIn = 1'b1;
				if (sinkS[i] < minHead)
					minHead = sinkS[i];
			end
		end
	end

	// Per-string open and short detection
	logic [3:0] openEvt;
	logic [3:0] shortEvt;
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_string
			logic [8:0] excess;
			assign excess = {1'b0, sinkS[g]} - {1'b0, minHead};
			assign openEvt[g] = checkStrings && openS[g];
			assign shortEvt[g] = checkStrings && anyIn && !openS[g]
				&& sinkS[g] > minHead && excess > margin;
		end
	endgenerate

	// Faulty string mask: set wins over a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
			stringBad_r <= 4'h0;
		else
			stringBad_r <= (clrFaults ? 4'h0 : stringBad_r) | openEvt | shortEvt;
	end

	// Supply monitor with hysteresis; releases by itself
	always_ff @(posedge mclk)
	begin
		if (srst)
			uvActive_r <= 1'b0;
		else if (uvThr == 8'h00)
			uvActive_r <= 1'b0;
		else if (supplyS < uvThr)
			uvActive_r <= 1'b1;
		else if ({1'b0, supplyS} >= {1'b0, uvThr} + {1'b0, SUPPLY_HYST})
			uvActive_r <= 1'b0;
	end

	// Thermal shutdown between 150 and 130 degC
	always_ff @(posedge mclk)
	begin
		if (srst)
			tsdActive_r <= 1'b0;
		else if (degC >= TSD_ON)
			tsdActive_r <= 1'b1;
		else if (degC < TSD_OFF)
			tsdActive_r <= 1'b0;
	end

	// Latched fault flags; a new event beats the clear
	logic uvEvt;
	logic ocEvt;
	logic tsdEvt;
	assign uvEvt = enS && uvThr != 8'h00 && supplyS < uvThr;
	assign ocEvt = enS && overCurS;
	assign tsdEvt = enS && degC >= TSD_ON;
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			openFlag_r <= 1'b0;
			shortFlag_r <= 1'b0;
			supplyFlag_r <= 1'b0;
			overCurFlag_r <= 1'b0;
			thermalFlag_r <= 1'b0;
		end
		else
		begin
			openFlag_r <= (openFlag_r && !clrFaults) || |openEvt;
			shortFlag_r <= (shortFlag_r && !clrFaults) || |shortEvt;
			supplyFlag_r <= (supplyFlag_r && !clrFaults) || uvEvt;
			overCurFlag_r <= (overCurFlag_r && !clrFaults) || ocEvt;
			thermalFlag_r <= (thermalFlag_r && !clrFaults) || tsdEvt;
		end
	end

	// Step interval divider for the boost loop
	always_ff @(posedge mclk)
	begin
		if (srst || shutdown)
			stepCnt_r <= '0;
		else if (stepTick)
			stepCnt_r <= '0;
		else
			stepCnt_r <= stepCnt_r + 1'b1;
	end
	assign stepTick = stepCnt_r == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1);

	// Adaptive boost; phase staggering changes only sink timing, so it is not consulted
	always_ff @(posedge mclk)
	begin
		if (srst || !enS)
			setpoint_r <= BOOST_INIT;
		else if (stepTick && anyIn)
		begin
			if (minHead < target && setpoint_r < BOOST_MAX)
				setpoint_r <= setpoint_r + 8'h01;
			else if ({1'b0, minHead} > {1'b0, target} + {1'b0, STEP_CODES}
				&& setpoint_r != 8'h00)
				setpoint_r <= setpoint_r - 8'h01;
		end
	end

	// Derating result; independent of all fault state
	logic [6:0] dutyCalc;
	lftm_derate u_derate (
		.degC(degC),
		.derateThresholdSel(cfg_r[CB_DERATE +: 2]),
		.duty(dutyCalc)
	);

	// Registered power-stage outputs
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ledEnable <= 1'b0;
			boostEnable <= 1'b0;
			boostSetpoint <= BOOST_INIT;
			dutyScale <= DUTY_FULL;
		end
		else
		begin
			ledEnable <= !shutdown;
			boostEnable <= !shutdown;
			boostSetpoint <= setpoint_r;
			dutyScale <= enS ? dutyCalc : DUTY_FULL;
		end
	end

	// Fault pin follows the latched flags only
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			faultPinOut <= 1'b0;
			faultPinOe <= 1'b0;
		end
		else
		begin
			faultPinOut <= 1'b0;
			faultPinOe <= openFlag_r || shortFlag_r || supplyFlag_r
				|| overCurFlag_r || thermalFlag_r;
		end
	end

	// Faulty string count for the fault register
	logic [2:0] badCount;
	always_comb
	begin
		badCount = 3'd0;
		for (int i = 0; i < 4; i++)
			badCount = badCount + {2'b00, stringBad_r[i]};
	end

	// Reading the high byte freezes the low bits for the next read
	always_ff @(posedge mclk)
	begin
		if (srst)
			tempLoHold_r <= 3'h0;
		else if (regRd && regAddr == ADDR_TEMP_HI)
			tempLoHold_r <= tempS[2:0];
	end

	// Read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk)
	begin
		if (srst)
			regRdata <= 8'h00;
		else if (regRd)
		begin
			case (regAddr)
				ADDR_FAULT: regRdata <= {thermalFlag_r, overCurFlag_r, supplyFlag_r,
					badCount, shortFlag_r, openFlag_r};
				ADDR_CFG: regRdata <= cfg_r;
				ADDR_CTRL: regRdata <= {7'h00, faultInPwm_r};
				ADDR_TEMP_HI: regRdata <= tempS[10:3];
				ADDR_TEMP_LO: regRdata <= {5'h00, tempLoHold_r};
				ADDR_STRINGS: regRdata <= {2'b00, tsdActive_r, uvActive_r, stringBad_r};
				ADDR_BOOST: regRdata <= setpoint_r;
				default: regRdata <= 8'h00;
			endcase
		end
		else
			regRdata <= 8'h00;
	end
endmodule : lftm_monitor

// file: bench/lftm_monitor_chk.sv
// Purpose: Port-level assertions for the fault and thermal monitor.
// Assumes: Pins pass a two-flop sync, then one register stage.
// Notes: Windows leave slack for the sync; checker is bound below.
module lftm_monitor_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	// Pins and sensors
	input wire logic enPin,
	input wire logic overCurrent,
	input wire logic [10:0] tempCode,
	// Power stage and fault pin
	input wire logic ledEnable,
	input wire logic boostEnable,
	input wire logic [7:0] boostSetpoint,
	input wire logic [6:0] dutyScale,
	input wire logic faultPinOut,
	input wire logic faultPinOe
);
	import lftm_pkg::*;
	// One domain, so one clock and one reset for every property
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	// A fault read is the only software path that may drop the pin
	logic rdFault;
	assign rdFault = regRd && regAddr == ADDR_FAULT;

	pin_data_low_a: assert property (faultPinOut == 1'b0)
		else $error("fault pin data not low");
	oc_shut_down_a: assert property ((enPin && overCurrent)[*6] |-> ##[0:3]
		(!ledEnable && !boostEnable && faultPinOe)) else $error("over-current not acted on");
	tsd_shut_down_a: assert property ((enPin && tempCode[10:3] >= TSD_ON)[*6] |-> ##[0:3]
		(!ledEnable && !boostEnable && faultPinOe)) else $error("hot die not shut down");
	pin_hold_a: assert property ((enPin && !rdFault)[*6] ##0 faultPinOe |=> faultPinOe)
		else $error("fault pin released without a clear");
	boost_step_a: assert property ($changed(boostSetpoint) |->
		(boostSetpoint == $past(boostSetpoint) + 8'h01 ||
		boostSetpoint == $past(boostSetpoint) - 8'h01 || boostSetpoint == BOOST_INIT))
		else $error("setpoint moved by more than one step");
	boost_ceiling_a: assert property (boostSetpoint <= BOOST_MAX)
		else $error("setpoint above ceiling");
	enable_off_a: assert property ((!enPin)[*6] |-> (!ledEnable && !boostEnable &&
		!faultPinOe && boostSetpoint == BOOST_INIT)) else $error("disabled chip still active");
	cool_full_duty_a: assert property ((tempCode[10:3] < DERATE_T1)[*5] |->
		dutyScale == DUTY_FULL) else $error("derating below lowest limit");
endmodule : lftm_monitor_chk

bind lftm_monitor lftm_monitor_chk chk (.mclk(mclk), .srst(srst), .regAddr(regAddr),
	.regRd(regRd), .enPin(enPin), .overCurrent(overCurrent), .tempCode(tempCode),
	.ledEnable(ledEnable), .boostEnable(boostEnable), .boostSetpoint(boostSetpoint),
	.dutyScale(dutyScale), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));

// file: bench/lftm_strings.sv
// Purpose: LED strings and boost stage as the sinks see them.
// Assumes: Boost is 10 V plus 125 mV a step; sink codes are 25 mV.
// Notes: An open string or a stopped stage leaves its sink at 0 V.
module lftm_strings (
	// Power stage
	input wire logic ledEnable,
	input wire logic [7:0] boostSetpoint,
	// String knobs
	input wire logic [3:0][9:0] vf,
	input wire logic [3:0] openMask,
	// Sink side
	output logic [3:0][7:0] sinkVolt,
	output logic [3:0] openCmp
);
	timeunit 1ns;
	timeprecision 1ps;
	// Headroom is boost output minus string drop, clipped to the sink range
	always_comb
	begin
		int h;
		h = 0;
		for (int i = 0; i < 4; i++)
		begin
			h = 400 + 5 * int'(boostSetpoint) - int'(vf[i]);
			if (!ledEnable || openMask[i] || h < 0)
				h = 0;
			sinkVolt[i] = (h > 255) ? 8'hff : h[7:0];
		end
	end
	assign openCmp = openMask; // Comparator trips while open
endmodule : lftm_strings

// file: bench/testbench.sv
// Purpose: Self-checking bench for the fault and thermal monitor.
// Assumes: Boost step interval shortened to 8 cycles.
// Notes: Fixed waits cover the two-flop sync plus one register stage.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import lftm_pkg::*;
	logic mclk = 0, srst = 1, regWr = 0, regRd = 0, enPin = 0, autoDimMode = 0, overCurrent = 0;
	logic [7:0] regAddr = 0, regWdata = 0, regRdata, supplyVolt = 8'hc8, boostSetpoint, rdv;
	logic [3:0][9:0] vf = {10'h258, 10'h258, 10'h190, 10'h258};
	logic [3:0][7:0] sinkVolt;
	logic [3:0] openCmp, openMask = 0;
	logic [10:0] tempCode = {8'h19, 3'h0};
	logic [6:0] dutyScale;
	logic ledEnable, boostEnable, faultPinOut, faultPinOe;
	int miscompares = 0, samplesChecked = 0;
	logic [7:0] thr [4] = '{8'h00, SUPPLY_THR1, SUPPLY_THR2, SUPPLY_THR3};
	logic [7:0] lim [4] = '{8'h8c, DERATE_T1, DERATE_T2, DERATE_T3};
	always #4 mclk = ~mclk;

	lftm_monitor #(.STEP_CYCLES(8)) DUT (.mclk(mclk), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.enPin(enPin), .autoDimMode(autoDimMode), .sinkVolt(sinkVolt), .openCmp(openCmp),
		.supplyVolt(supplyVolt), .overCurrent(overCurrent), .tempCode(tempCode),
		.ledEnable(ledEnable), .boostEnable(boostEnable), .boostSetpoint(boostSetpoint),
		.dutyScale(dutyScale), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));
	lftm_strings plant (.ledEnable(ledEnable), .boostSetpoint(boostSetpoint), .vf(vf),
		.openMask(openMask), .sinkVolt(sinkVolt), .openCmp(openCmp));

	// Compare and count; case equality so an unknown never matches
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		samplesChecked++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe; taken at the edge that ends it
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
		rdv = regRdata;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
		rd(a);
		chk(n, e, rdv);
	endtask : rdc
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : endOfTest

	// Watchdog: tests need about 2900 cycles
	initial
	begin
		tick(20000);
		miscompares++;
		endOfTest;
	end

	initial
	begin
		tick(6);
		srst <= 1'b0;
		rdc(ADDR_CFG, CFG_RST, "cfg reset");
		rdc(8'h07, 8'h00, "unmapped");
		rdc(ADDR_BOOST, BOOST_INIT, "setpoint off");
		$display("test regs done");
		enPin <= 1'b1;
		tick(2000);
		rdc(ADDR_BOOST, 8'h2b, "boost sel0");
		wr(ADDR_CFG, 8'h07);
		tick(300);
		rdc(ADDR_BOOST, 8'h32, "boost sel7");
		rdc(ADDR_FAULT, 8'h00, "pwm only");
		// Control bit forces string checks in pure PWM dimming
		wr(ADDR_CTRL, 8'h01);
		tick(20);
		rdc(ADDR_CTRL, 8'h01, "ctrl");
		rdc(ADDR_FAULT, 8'h06, "pwm forced");
		wr(ADDR_CTRL, 8'h00);
		$display("test boost done");
		autoDimMode <= 1'b1;
		tick(20);
		chk("pin", 8'h01, {7'h00, faultPinOe});
		rdc(ADDR_FAULT, 8'h06, "short");
		wr(ADDR_CFG, 8'h0f);
		tick(10);
		rd(ADDR_FAULT);
		tick(10);
		rdc(ADDR_FAULT, 8'h00, "margin hi");
		vf[1] <= 10'h258;
		openMask <= 4'h4;
		tick(100);
		rdc(ADDR_STRINGS, 8'h04, "mask");
		rdc(ADDR_FAULT, 8'h05, "open");
		rdc(ADDR_BOOST, 8'h32, "excluded");
		openMask <= 4'h0;
		tick(10);
		rd(ADDR_FAULT);
		tick(10);
		rdc(ADDR_FAULT, 8'h00, "cleared");
		chk("pin off", 8'h00, {7'h00, faultPinOe});
		$display("test strings done");
		// Walk every supply threshold code
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CFG, {2'h0, i[1:0], 4'hf});
			supplyVolt <= (i == 0) ? 8'h00 : thr[i] - 8'h02;
			tick(10);
			chk("uv", (i == 0) ? 8'h01 : 8'h00, {7'h00, ledEnable});
			supplyVolt <= thr[i] + 8'h02;
			tick(10);
			chk("hyst", (i == 0) ? 8'h01 : 8'h00, {7'h00, ledEnable});
			rdc(ADDR_STRINGS, (i == 0) ? 8'h00 : 8'h10, "uv active");
			supplyVolt <= thr[i] + 8'h08;
			tick(10);
			chk("restart", 8'h01, {7'h00, ledEnable});
			rdc(ADDR_FAULT, (i == 0) ? 8'h00 : 8'h20, "uv flag");
		end
		supplyVolt <= 8'hc8;
		$display("test supply done");
		overCurrent <= 1'b1;
		tick(10);
		chk("oc led", 8'h00, {7'h00, ledEnable});
		overCurrent <= 1'b0;
		tick(20);
		chk("oc latch", 8'h00, {7'h00, boostEnable});
		rdc(ADDR_FAULT, 8'h40, "oc flag");
		tick(10);
		chk("oc clear", 8'h01, {7'h00, ledEnable});
		$display("test overcurrent done");
		// Every derate code, each 5 degC past its limit
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CFG, {i[1:0], 6'h0f});
			tempCode <= {lim[i] + 8'h05, 3'h3};
			tick(10);
			chk("duty", (i == 0) ? 8'h64 : 8'h5a, {1'b0, dutyScale});
			chk("derate quiet", 8'h00, {7'h00, faultPinOe});
		end
		rdc(ADDR_TEMP_HI, 8'h87, "temp hi");
		tempCode <= {8'h87, 3'h6};
		tick(5);
		rdc(ADDR_TEMP_LO, 8'h03, "temp lo");
		wr(ADDR_CFG, 8'h0f);
		tempCode <= {TSD_ON, 3'h0};
		tick(10);
		chk("tsd", 8'h00, {7'h00, ledEnable});
		tempCode <= {8'h87, 3'h0};
		tick(10);
		chk("tsd hold", 8'h00, {7'h00, ledEnable});
		rdc(ADDR_STRINGS, 8'h20, "tsd active");
		tempCode <= {8'h7d, 3'h0};
		tick(10);
		chk("tsd resume", 8'h01, {7'h00, ledEnable});
		rdc(ADDR_FAULT, 8'h80, "tsd flag");
		$display("test thermal done");
		overCurrent <= 1'b1;
		tick(5);
		overCurrent <= 1'b0;
		tick(5);
		enPin <= 1'b0;
		tick(10);
		chk("en pin", 8'h00, {7'h00, faultPinOe});
		enPin <= 1'b1;
		tick(10);
		rdc(ADDR_FAULT, 8'h00, "en clear");
		$display("test enable done");
		endOfTest;
	end
endmodule : testbench
